// *** hdl/uts_map.vh ***
// Register map, field positions, reset values and timing for the USB termination select block
`ifndef UTS_MAP_VH
`define UTS_MAP_VH
`define UTS_OFS_FUNC_CTRL 8'h00
`define UTS_OFS_OTG_CTRL  8'h04
`define UTS_OFS_HS_COMP   8'h08
`define UTS_OFS_STATUS    8'h0c
`define UTS_OFS_TX_DATA   8'h10
`define UTS_OFS_RX_DATA   8'h14
`define UTS_FC_XS_LSB     0
`define UTS_FC_TS_BIT     2
`define UTS_FC_OM_LSB     3
`define UTS_OTG_DP_BIT    1
`define UTS_OTG_DM_BIT    2
`define UTS_HC_BOOST_LSB  0
`define UTS_HC_SENSE_LSB  4
`define UTS_RST_FUNC_CTRL 5'h01
`define UTS_RST_OTG_CTRL  3'h6
`define UTS_TERM_DEFAULT  5'h06
`define UTS_BIT_DIV       4
`define UTS_STUFF_LIMIT   3'h6
`endif

// *** hdl/uts_fifo.v ***
// Transmit byte FIFO with valid/ready on both sides
`timescale 1ns/1ps
module uts_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             full,
  output wire             empty
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr_ff;
  reg [AW:0]      rd_ptr_ff;
  wire            push;
  wire            pop;

  assign full      = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  assign empty     = (wr_ptr_ff == rd_ptr_ff);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr_ff[AW-1:0]];
  assign push      = in_valid && !full;
  assign pop       = out_ready && !empty;

  always @(posedge pclk)
  begin
    if (push)
      mem[wr_ptr_ff[AW-1:0]] <= in_data;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr_ff <= {(AW+1){1'b0}};
      rd_ptr_ff <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_ff <= wr_ptr_ff + {{AW{1'b0}}, 1'b1};
      if (pop)
        rd_ptr_ff <= rd_ptr_ff + {{AW{1'b0}}, 1'b1};
    end
  end
endmodule

// *** hdl/uts_top.v ***
// Termination decode, compensation settings and serial TX/RX path behind an APB slave
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ps
`include "uts_map.vh"
module uts_top #(
  parameter BIT_DIV = `UTS_BIT_DIV
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        hardware_reset_n,
  input  wire        hs_rx_data,
  input  wire        fs_rx_data,
  input  wire        hs_squelch,
  input  wire        dp_se_rx,
  input  wire        dm_se_rx,
  output wire        dp_pull_up_enable,
  output wire        dm_pull_up_enable,
  output wire        dp_pull_down_enable,
  output wire        dm_pull_down_enable,
  output wire        high_speed_termination_enable,
  output wire [1:0]  tx_amplitude_boost,
  output wire [1:0]  squelch_sensitivity,
  output wire        hs_tx_data,
  output wire        hs_tx_oe,
  output wire        fs_tx_data,
  output wire        fs_tx_oe,
  output wire [1:0]  rx_line_state
);
  localparam ST_IDLE  = 3'b001;
  localparam ST_SHIFT = 3'b010;
  // Final bit on the line, driver still enabled
  localparam ST_HOLD  = 3'b100;

  // ****************************************************
  // Termination decode
  // ****************************************************
  // Returns {pu_dp, pu_dm, pd_dp, pd_dm, hs_term}
  function [4:0] uts_term_decode;
    input [1:0] xs;
    input       ts;
    input [1:0] om;
    input       dpp;
    input       dmp;
    reg         hs_sel;
    reg         act;
    begin
      hs_sel = (xs == 2'b00) && !ts && (om == 2'b00 || om == 2'b10);
      act    = (om == 2'b00) || (om == 2'b10);
      // Mode 01 wins over every other field; unlisted settings keep both pull-downs
      uts_term_decode = `UTS_TERM_DEFAULT;
      if (om == 2'b01)
        uts_term_decode = 5'h00;
      else if (dpp && dmp)
      begin
        if (hs_sel)
          uts_term_decode = 5'h07;
      end
      else if (!dpp && !dmp)
      begin
        if (hs_sel)
          uts_term_decode = 5'h01;
        else if (ts && act && ((xs == 2'b00 && om == 2'b10) || xs == 2'b01))
          uts_term_decode = 5'h10;
        else if (ts && act && xs == 2'b10)
          uts_term_decode = 5'h08;
      end
      else if (!dpp && dmp)
      begin
        if (hs_sel)
          uts_term_decode = 5'h03;
        else if (ts && act && ((xs == 2'b00 && om == 2'b10) || xs == 2'b01))
          uts_term_decode = 5'h12;
        else if (xs == 2'b01 && !ts && om == 2'b00)
          uts_term_decode = 5'h02;
      end
    end
  endfunction

  // ****************************************************
  // Synchronisers
  // ****************************************************
  reg  [5:0] sync1_ff;
  reg  [5:0] sync2_ff;
  wire       hw_run;
  wire       hs_rx_s;
  wire       fs_rx_s;
  wire       squelch_s;
  // Pin inputs are asynchronous to pclk; only the second stage is read

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_ff <= 6'h00;
      sync2_ff <= 6'h00;
    end
    else
    begin
      sync1_ff <= {hardware_reset_n, hs_rx_data, fs_rx_data, hs_squelch, dm_se_rx, dp_se_rx};
      sync2_ff <= sync1_ff;
    end
  end

  assign hw_run        = sync2_ff[5];
  assign hs_rx_s       = sync2_ff[4];
  assign fs_rx_s       = sync2_ff[3];
  assign squelch_s     = sync2_ff[2];
  assign rx_line_state = sync2_ff[1:0];

  // ****************************************************
  // APB registers
  // ****************************************************
  reg  [4:0]  func_ctrl_ff;
  reg  [2:0]  otg_ctrl_ff;
  reg  [7:0]  hs_comp_ff;
  reg  [31:0] prdata_ff;
  reg  [4:0]  term_ff;
  reg  [7:0]  rx_byte_ff;
  reg         busy_ff;
  wire        fifo_in_ready;
  wire        fifo_full;
  wire        fifo_empty;
  wire        sel_tx;
  wire        mapped;
  wire        wr_ok;
  reg  [31:0] nxt_prdata;

  assign sel_tx  = (paddr == `UTS_OFS_TX_DATA);
  assign mapped  = (paddr == `UTS_OFS_FUNC_CTRL) || (paddr == `UTS_OFS_OTG_CTRL) || (paddr == `UTS_OFS_HS_COMP)
                || (paddr == `UTS_OFS_STATUS) || sel_tx || (paddr == `UTS_OFS_RX_DATA);
  // A TX write waits in the access phase while the FIFO is full
  assign pready  = !(pwrite && sel_tx && !fifo_in_ready);
  // Unmapped addresses answer with an error and change nothing
  assign pslverr = psel && penable && !mapped;
  assign prdata  = prdata_ff;
  assign wr_ok   = psel && penable && pwrite && pready;

  always @*
  begin
    nxt_prdata = 32'h0000_0000;
    case (paddr)
      `UTS_OFS_FUNC_CTRL: nxt_prdata = {27'h0000000, func_ctrl_ff};
      `UTS_OFS_OTG_CTRL:  nxt_prdata = {29'h00000000, otg_ctrl_ff};
      `UTS_OFS_HS_COMP:   nxt_prdata = {24'h000000, hs_comp_ff};
      `UTS_OFS_STATUS:    nxt_prdata = {20'h00000, rx_line_state, hw_run, busy_ff,
                                        fifo_full, fifo_empty, 1'b0, term_ff};
      `UTS_OFS_RX_DATA:   nxt_prdata = {24'h000000, rx_byte_ff};
      default:            nxt_prdata = 32'h0000_0000;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      func_ctrl_ff <= `UTS_RST_FUNC_CTRL;
      otg_ctrl_ff  <= `UTS_RST_OTG_CTRL;
      hs_comp_ff   <= 8'h00;
      prdata_ff    <= 32'h0000_0000;
    end
    else
    begin
      // Read data is captured in the setup cycle and stands through the access phase
      if (psel && !penable && !pwrite)
        prdata_ff <= nxt_prdata;
      if (wr_ok && paddr == `UTS_OFS_FUNC_CTRL)
        func_ctrl_ff <= pwdata[4:0];
      if (wr_ok && paddr == `UTS_OFS_OTG_CTRL)
        otg_ctrl_ff <= {pwdata[`UTS_OTG_DM_BIT], pwdata[`UTS_OTG_DP_BIT], 1'b0};
      if (wr_ok && paddr == `UTS_OFS_HS_COMP)
        hs_comp_ff <= {2'b00, pwdata[`UTS_HC_SENSE_LSB+1:`UTS_HC_SENSE_LSB], 2'b00,
                       pwdata[`UTS_HC_BOOST_LSB+1:`UTS_HC_BOOST_LSB]};
    end
  end

  assign tx_amplitude_boost  = hs_comp_ff[`UTS_HC_BOOST_LSB+1:`UTS_HC_BOOST_LSB];
  assign squelch_sensitivity = hs_comp_ff[`UTS_HC_SENSE_LSB+1:`UTS_HC_SENSE_LSB];

  // Speed select also picks which driver pair and receiver are in use
  wire [1:0] xs_sel = func_ctrl_ff[`UTS_FC_XS_LSB+1:`UTS_FC_XS_LSB];
  wire       hs_mode = (xs_sel == 2'b00);

  // ****************************************************
  // Registered termination enables
  // ****************************************************
  // One clock of latency buys glitch-free pad enables
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      term_ff <= 5'h00;
    else if (!hw_run)
      term_ff <= 5'h00;
    else
      term_ff <= uts_term_decode(xs_sel, func_ctrl_ff[`UTS_FC_TS_BIT],
                                 func_ctrl_ff[`UTS_FC_OM_LSB+1:`UTS_FC_OM_LSB],
                                 otg_ctrl_ff[1], otg_ctrl_ff[2]);
  end

  assign dp_pull_up_enable             = term_ff[4];
  assign dm_pull_up_enable             = term_ff[3];
  assign dp_pull_down_enable           = term_ff[2];
  assign dm_pull_down_enable           = term_ff[1];
  assign high_speed_termination_enable = term_ff[0];

  // ****************************************************
  // Bit rate enable
  // ****************************************************
  reg  [7:0] div_ff;
  wire       bit_en = (div_ff == 8'h00);
  // Free running, so the first bit of a byte may start up to BIT_DIV-1 clocks late;
  // transmit and receive then share one bit grid

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_ff <= 8'h00;
    else if (bit_en)
      div_ff <= BIT_DIV[7:0] - 8'h01;
    else
      div_ff <= div_ff - 8'h01;
  end

  // ****************************************************
  // Transmit: FIFO, serialize, stuff, NRZI
  // ****************************************************
  wire       fifo_out_valid;
  wire [7:0] fifo_out_data;
  reg  [2:0] state_ff;
  reg  [7:0] shift_ff;
  reg  [2:0] bit_cnt_ff;
  reg  [2:0] ones_ff;
  reg        line_ff;
  wire       take = (state_ff == ST_IDLE) && fifo_out_valid && hw_run;
  wire       last_bit;
  // Line starts at 1 and keeps its level between bytes, so NRZI runs on across them

  // The FIFO decouples APB writes from the slow bit rate
  uts_fifo #(
    .WIDTH (8),
    .DEPTH (16),
    .AW    (4)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (wr_ok && sel_tx),
    .in_ready  (fifo_in_ready),
    .in_data   (pwdata[7:0]),
    .out_valid (fifo_out_valid),
    .out_ready (take),
    .out_data  (fifo_out_data),
    .full      (fifo_full),
    .empty     (fifo_empty)
  );

  assign last_bit = (bit_cnt_ff == 3'h7) && (ones_ff != `UTS_STUFF_LIMIT);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff   <= ST_IDLE;
      shift_ff   <= 8'h00;
      bit_cnt_ff <= 3'h0;
      ones_ff    <= 3'h0;
      line_ff    <= 1'b1;
      busy_ff    <= 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          if (take)
          begin
            shift_ff   <= fifo_out_data;
            bit_cnt_ff <= 3'h0;
            busy_ff    <= 1'b1;
            state_ff   <= ST_SHIFT;
          end
        end
        ST_SHIFT:
        begin
          if (!hw_run)
          begin
            busy_ff  <= 1'b0;
            ones_ff  <= 3'h0;
            state_ff <= ST_IDLE;
          end
          else if (bit_en)
          begin
            // Six ones in a row: a stuffed zero, which toggles the line
            if (ones_ff == `UTS_STUFF_LIMIT)
            begin
              line_ff <= !line_ff;
              ones_ff <= 3'h0;
            end
            else
            begin
              // NRZI: a zero toggles the line, a one holds it
              if (!shift_ff[0])
                line_ff <= !line_ff;
              ones_ff    <= shift_ff[0] ? ones_ff + 3'h1 : 3'h0;
              shift_ff   <= {1'b0, shift_ff[7:1]};
              bit_cnt_ff <= bit_cnt_ff + 3'h1;
            end
            // The last bit has just been put on the line and still needs its bit time
            if (last_bit)
              state_ff <= ST_HOLD;
          end
        end
        ST_HOLD:
        begin
          // Abort drops the byte and releases the line at once
          if (!hw_run)
          begin
            busy_ff  <= 1'b0;
            ones_ff  <= 3'h0;
            state_ff <= ST_IDLE;
          end
          else if (bit_en)
          begin
            busy_ff  <= 1'b0;
            state_ff <= ST_IDLE;
          end
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

  // Drivers released whenever the synchronised hardware reset pin (hw_run) is low, two clocks after the pin itself
  // A released driver shows 0; the pull resistors decide the line level then
  assign hs_tx_data = busy_ff && hw_run && hs_mode && line_ff;
  assign hs_tx_oe   = busy_ff && hw_run && hs_mode;
  assign fs_tx_data = busy_ff && hw_run && !hs_mode && line_ff;
  assign fs_tx_oe   = busy_ff && hw_run && !hs_mode;

  // ****************************************************
  // Receive: mux, squelch gate, deserialize
  // ****************************************************
  // Squelch holds off HS bits so line noise never fills the byte
  wire       rx_bit   = hs_mode ? hs_rx_s : fs_rx_s;
  wire       rx_take  = bit_en && hw_run && !(hs_mode && squelch_s);
  reg  [7:0] rx_sh_ff;
  reg  [2:0] rx_cnt_ff;
  // No framing: the deserializer runs free on the bit grid and software aligns bytes

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_sh_ff   <= 8'h00;
      rx_cnt_ff  <= 3'h0;
      rx_byte_ff <= 8'h00;
    end
    else if (rx_take)
    begin
      rx_sh_ff  <= {rx_bit, rx_sh_ff[7:1]};
      rx_cnt_ff <= rx_cnt_ff + 3'h1;
      if (rx_cnt_ff == 3'h7)
        rx_byte_ff <= {rx_bit, rx_sh_ff[7:1]};
    end
  end
endmodule

// *** verification/uts_assertions.sv ***
// Checker for the termination decode, reset pin and compensation outputs
`timescale 1ns/1ps
module uts_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        hardware_reset_n,
  input wire        dp_pull_up_enable,
  input wire        dm_pull_up_enable,
  input wire        dp_pull_down_enable,
  input wire        dm_pull_down_enable,
  input wire        high_speed_termination_enable,
  input wire [1:0]  tx_amplitude_boost,
  input wire [1:0]  squelch_sensitivity
);
  // ********
  // Shadow of the control fields
  // ********
  reg  [4:0] fc_ff;
  reg  [2:0] otg_ff;
  reg  [1:0] hw_cnt_ff;
  wire       wr = psel && penable && pready && pwrite;
  wire [1:0] xs = fc_ff[1:0];
  wire       ts = fc_ff[2];
  wire [1:0] om = fc_ff[4:3];
  wire [1:0] pd = otg_ff[2:1];
  wire       ok = hw_cnt_ff == 2'h3;
  wire [4:0] term = {dp_pull_up_enable, dm_pull_up_enable, dp_pull_down_enable, dm_pull_down_enable,
                     high_speed_termination_enable};
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      fc_ff     <= 5'h01;
      otg_ff    <= 3'h6;
      hw_cnt_ff <= 2'h0;
    end
    else
    begin
      if (wr && paddr == 8'h00)
        fc_ff <= pwdata[4:0];
      if (wr && paddr == 8'h04)
        otg_ff <= pwdata[2:0];
      // Decode is only trusted once the pin has crossed its synchroniser
      hw_cnt_ff <= !hardware_reset_n ? 2'h0 : (ok ? hw_cnt_ff : hw_cnt_ff + 2'h1);
    end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_pin_low;
    !hardware_reset_n [*3];
  endsequence
  sequence s_comp_write;
    wr && paddr == 8'h08;
  endsequence
  a_mode_off: assert property (ok && om == 2'h1 |=> term == 5'h00) else $error("mode off");
  a_power_up: assert property (ok && fc_ff == 5'h01 && pd == 2'h3 |=> term == 5'h06) else $error("power up");
  a_host_hs: assert property (ok && pd == 2'h3 && xs == 2'h0 && !ts && !om[0] |=> term == 5'h07)
    else $error("host hs");
  a_host_fs: assert property (ok && pd == 2'h3 && xs != 2'h0 && ts && om != 2'h1 |=> term == 5'h06)
    else $error("host fs");
  a_perif_fs: assert property (ok && pd == 2'h0 && ts && !om[0] && (xs == 2'h1 || xs == 2'h0 && om == 2'h2)
    |=> term == 5'h10) else $error("perif fs");
  a_perif_hs: assert property (ok && pd == 2'h0 && xs == 2'h0 && !ts && !om[0] |=> term == 5'h01)
    else $error("perif hs");
  a_perif_ls: assert property (ok && pd == 2'h0 && xs == 2'h2 && ts && !om[0] |=> term == 5'h08)
    else $error("perif ls");
  a_otg_fs: assert property (ok && pd == 2'h2 && ts && !om[0] && (xs == 2'h1 || xs == 2'h0 && om == 2'h2)
    |=> term == 5'h12) else $error("otg fs");
  a_otg_hs: assert property (ok && pd == 2'h2 && xs == 2'h0 && !ts && !om[0] |=> term == 5'h03)
    else $error("otg hs");
  a_fall_back: assert property (ok && om != 2'h1 && (pd == 2'h1 || om == 2'h3) |=> term == 5'h06)
    else $error("fallback");
  a_pin_off: assert property (s_pin_low |=> term == 5'h00) else $error("pin low");
  a_comp_follow: assert property (s_comp_write |=> tx_amplitude_boost == $past(pwdata[1:0]) &&
    squelch_sensitivity == $past(pwdata[5:4])) else $error("comp");
endmodule
bind uts_top uts_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .hardware_reset_n(hardware_reset_n),
  .dp_pull_up_enable(dp_pull_up_enable), .dm_pull_up_enable(dm_pull_up_enable),
  .dp_pull_down_enable(dp_pull_down_enable), .dm_pull_down_enable(dm_pull_down_enable),
  .high_speed_termination_enable(high_speed_termination_enable),
  .tx_amplitude_boost(tx_amplitude_boost), .squelch_sensitivity(squelch_sensitivity)
);

// *** verification/uts_line.sv ***
// Line-side model: echoes the driven line to the receivers and counts transmitted transitions
`timescale 1ns/1ps
module uts_line (
  input  wire pclk,
  input  wire hs_tx_data,
  input  wire hs_tx_oe,
  input  wire fs_tx_data,
  input  wire fs_tx_oe,
  input  wire idle_level,
  input  wire squelch_req,
  output wire hs_rx_data,
  output wire fs_rx_data,
  output wire hs_squelch,
  output wire dp_se_rx,
  output wire dm_se_rx
);
  // Last level the driver showed; an undriven line keeps no driven level of its own
  reg     prev_ff = 1'b1;
  integer toggles = 0;
  wire    txd  = hs_tx_oe ? hs_tx_data : fs_tx_data;
  // Undriven line rests at the level the pull resistors give it
  wire    line = (hs_tx_oe || fs_tx_oe) ? txd : idle_level;
  assign hs_rx_data = line;
  assign fs_rx_data = line;
  assign hs_squelch = squelch_req;
  assign dp_se_rx   = line;
  assign dm_se_rx   = ~line;
  always @(posedge pclk)
  begin
    if (hs_tx_oe || fs_tx_oe)
    begin
      if (txd != prev_ff)
        toggles <= toggles + 1;
      prev_ff <= txd;
    end
  end
endmodule

// *** verification/testbench.sv ***
// Bench: register access, termination table, reset pin, FIFO and serial path
`timescale 1ns/1ps
module testbench;
  localparam integer BDIV = 2;
  // Entries are {func_ctrl, otg_ctrl, expected enables}
  localparam logic [0:20][19:0] TBL = {20'h0e600, 20'h08000, 20'h01606, 20'h10607, 20'h00607, 20'h07606,
    20'h16606, 20'h14010, 20'h05010, 20'h00001, 20'h10001, 20'h06008, 20'h16008, 20'h14412, 20'h05412,
    20'h15412, 20'h00403, 20'h10403, 20'h18606, 20'h05206, 20'h01402};
  logic        pclk, presetn, psel, penable, pwrite, hardware_reset_n, idle_level, squelch_req, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, q;
  wire  [31:0] prdata;
  wire         pready, pslverr, hs_rx, fs_rx, hs_sq, dp_se, dm_se, hs_td, hs_oe, fs_td, fs_oe;
  wire         pu_dp, pu_dm, pd_dp, pd_dm, hs_term;
  wire  [1:0]  boost, sense, line_state;
  wire  [4:0]  term = {pu_dp, pu_dm, pd_dp, pd_dm, hs_term};
  integer      n_errors, num_checks, k, base;
  uts_top #(.BIT_DIV(BDIV)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hardware_reset_n(hardware_reset_n),
    .hs_rx_data(hs_rx), .fs_rx_data(fs_rx), .hs_squelch(hs_sq), .dp_se_rx(dp_se), .dm_se_rx(dm_se),
    .dp_pull_up_enable(pu_dp), .dm_pull_up_enable(pu_dm), .dp_pull_down_enable(pd_dp),
    .dm_pull_down_enable(pd_dm), .high_speed_termination_enable(hs_term), .tx_amplitude_boost(boost),
    .squelch_sensitivity(sense), .hs_tx_data(hs_td), .hs_tx_oe(hs_oe), .fs_tx_data(fs_td), .fs_tx_oe(fs_oe),
    .rx_line_state(line_state));
  uts_line u_line (
    .pclk(pclk), .hs_tx_data(hs_td), .hs_tx_oe(hs_oe), .fs_tx_data(fs_td), .fs_tx_oe(fs_oe),
    .idle_level(idle_level), .squelch_req(squelch_req), .hs_rx_data(hs_rx), .fs_rx_data(fs_rx),
    .hs_squelch(hs_sq), .dp_se_rx(dp_se), .dm_se_rx(dm_se));
  // ********
  // Access and compare tasks
  // ********
  task stop_test;
    begin
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    begin
      num_checks++;
      if (got !== exp)
      begin
        n_errors++;
        $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    integer i;
    begin
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // A full FIFO may hold the write until the transmitter takes its next byte, hence the generous bound
      for (i = 0; pready !== 1'b1 && i < 3000; i++)
        @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (i == 3000)
      begin
        n_errors++;
        $display("mismatch pready expected 1 seen 0");
        stop_test;
      end
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    begin
      apb(1'b0, a, 32'h0);
      chk(nm, exp, q);
    end
  endtask
  task drain;
    integer i;
    begin
      for (i = 0; i < 200; i++)
      begin
        apb(1'b0, 8'h0c, 32'h0);
        if (q[6] && !q[8])
          break;
      end
      chk("drained", 32'h1, {31'h0, q[6] && !q[8]});
    end
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial
  begin
    n_errors = 0;
    num_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    hardware_reset_n = 1'b1;
    idle_level = 1'b1;
    squelch_req = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, 32'h01, "func_ctrl");
    rd(8'h04, 32'h06, "otg_ctrl");
    rd(8'h08, 32'h00, "hs_comp");
    chk("term_power_up", 32'h06, {27'h0, term});
    rd(8'h18, 32'h00, "unmapped_data");
    chk("unmapped_err", 32'h1, {31'h0, e});
    for (k = 0; k < 21; k++)
    begin
      apb(1'b1, 8'h00, {24'h0, TBL[k][19:12]});
      apb(1'b1, 8'h04, {28'h0, TBL[k][11:8]});
      @(posedge pclk);
      #1;
      chk("term", {24'h0, TBL[k][7:0]}, {27'h0, term});
    end
    apb(1'b1, 8'h08, 32'h31);
    rd(8'h08, 32'h31, "hs_comp_rb");
    chk("comp_out", 32'h7, {28'h0, boost, sense});
    apb(1'b1, 8'h00, 32'h01);
    apb(1'b1, 8'h04, 32'h06);
    hardware_reset_n <= 1'b0;
    repeat (4) @(posedge pclk);
    #1;
    chk("term_pin_low", 32'h0, {27'h0, term});
    base = u_line.toggles;
    for (k = 0; k < 16; k++)
      apb(1'b1, 8'h10, 32'h0);
    rd(8'h0c, 32'h480, "status_full");
    fork
      apb(1'b1, 8'h10, 32'h0);
      begin
        repeat (6) @(posedge pclk);
        chk("stall", 32'h0, {31'h0, pready});
        hardware_reset_n <= 1'b1;
      end
    join
    drain;
    chk("toggles_fs", 32'd136, u_line.toggles - base);
    apb(1'b1, 8'h00, 32'h00);
    base = u_line.toggles;
    apb(1'b1, 8'h10, 32'hff);
    drain;
    chk("toggles_hs", 32'h1, u_line.toggles - base);
    apb(1'b1, 8'h00, 32'h01);
    repeat (100) @(posedge pclk);
    rd(8'h14, 32'hff, "rx_fs");
    chk("line_j", 32'h1, {30'h0, line_state});
    squelch_req <= 1'b1;
    apb(1'b1, 8'h00, 32'h00);
    idle_level <= 1'b0;
    repeat (100) @(posedge pclk);
    rd(8'h14, 32'hff, "rx_squelched");
    chk("line_k", 32'h2, {30'h0, line_state});
    stop_test;
  end
endmodule
